// ---- src/itp_regs.svh ----
// Register map, field positions, codes and constants of the interrupt and trap prioritizer
`ifndef ITP_REGS_SVH
`define ITP_REGS_SVH

// Register byte offsets
`define ITP_SRC_BASE 8'h00
`define ITP_SRC_LAST 8'h3c
`define ITP_TRAP_FLAG_OFS 8'h40
`define ITP_PEC_ROUTE_OFS 8'h44
`define ITP_STATUS_OFS 8'h48

// Source control register fields
`define ITP_GROUP_ORDER_FIELD_LSB 0
`define ITP_GROUP_ORDER_FIELD_MSB 1
`define ITP_PRIORITY_LEVEL_FIELD_LSB 2
`define ITP_PRIORITY_LEVEL_FIELD_MSB 5
`define ITP_ENABLE_BIT 6
`define ITP_PEND_BIT 7
`define ITP_SRC_RESET 8'h00
`define ITP_NUM_SRC 16

// Trap flag register fields; class B flags sit in bits 5:0
`define ITP_TF_NMI 15
`define ITP_TF_OVER 14
`define ITP_TF_UNDER 13
`define ITP_TF_CLASSB_MSB 5
`define ITP_TF_RESET 16'h0000

// Status register fields
`define ITP_ST_LEVEL_MSB 3
`define ITP_ST_CLASS_LSB 4
`define ITP_ST_CLASS_MSB 5
`define ITP_ST_BRANCH_BIT 8
`define ITP_ST_PEC_BIT 9

// Trap numbers
`define ITP_TN_RESET 7'h00
`define ITP_TN_NMI 7'h02
`define ITP_TN_OVER 7'h04
`define ITP_TN_UNDER 7'h06
`define ITP_TN_CLASSB 7'h0a
`define ITP_TN_CH21 7'h35
`define ITP_TN_CH29 7'h44
`define ITP_TN_XP0 7'h40
`define ITP_TN_TXBUF 7'h47

// Source index boundaries of the number groups
`define ITP_IDX_CH29 4'h8
`define ITP_IDX_XP0 4'hb
`define ITP_IDX_TXBUF 4'hf

// Priority levels
`define ITP_LEVEL_MAX 4'hf
`define ITP_LEVEL_RESET 4'h0

// AHB codes
`define ITP_HSIZE_BYTE 3'h0
`define ITP_HSIZE_HALF 3'h1
`define ITP_HSIZE_WORD 3'h2

`endif

// ---- src/itp_pkg.sv ----
// Types of the interrupt and trap prioritizer
package itp_pkg;

    typedef enum logic [2:0] {
        KIND_NONE = 3'h0,
        KIND_IRQ = 3'h1,
        KIND_SWT = 3'h3,
        KIND_TRB = 3'h2,
        KIND_TRA = 3'h6,
        KIND_RST = 3'h7
    } itp_kind_type;

    typedef enum logic [1:0] {
        CLS_NONE = 2'h0,
        CLS_B = 2'h1,
        CLS_A = 2'h2,
        CLS_RST = 2'h3
    } itp_class_type;

endpackage : itp_pkg

// ---- src/itp_prioritizer.sv ----
// Interrupt and trap prioritizer with AHB-Lite register slave
`timescale 1ns/100ps
`include "itp_regs.svh"

module itp_prioritizer (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Source requests, one-cycle pulses
    input wire logic [15:0] src_req,
    // Trap conditions
    input wire logic [2:0] reset_evt,
    input wire logic nmi_pin,
    input wire logic stack_over_evt,
    input wire logic stack_under_evt,
    input wire logic [5:0] class_b_evt,
    // Software trap instruction
    input wire logic sw_trap_valid,
    input wire logic [6:0] sw_trap_num,
    // Core vectoring
    output logic branch_req,
    output logic [23:0] branch_addr,
    output logic [6:0] branch_num,
    output logic [2:0] branch_kind,
    output logic [3:0] branch_level,
    input wire logic branch_ack,
    input wire logic trap_done,
    input wire logic irq_return,
    input wire logic [3:0] ret_level,
    // Event transfer
    output logic pec_req,
    output logic [3:0] pec_src,
    input wire logic pec_ack,
    // Processor priority
    output logic [3:0] cpu_level
);

    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic wr_q;
    logic [7:0] wr_addr_q;
    logic [1:0] wr_be_q;
    logic rd_src_q;
    logic [31:0] rd_d;
    logic addr_ok;
    logic [1:0] be_d;
    logic [7:0] src_ctl_q [16];
    logic [15:0] trap_flag_q;
    logic [15:0] pec_route_q;
    logic nmi_s1_q, nmi_s2_q, nmi_s3_q, nmi_lvl_q;
    logic nmi_evt;
    logic rst_pend_q, b_pend_q, swt_pend_q;
    logic [2:0] a_pend_q;
    logic [6:0] swt_num_q;
    itp_pkg::itp_class_type active_q;
    logic [3:0] cpu_level_q, saved_level_q;
    logic branch_req_q;
    logic [23:0] branch_addr_q;
    logic [6:0] branch_num_q;
    itp_pkg::itp_kind_type kind_q, kind_d;
    logic [3:0] branch_level_q, level_d;
    logic [3:0] branch_src_q;
    logic pec_req_q;
    logic [3:0] pec_src_q;
    logic [6:0] num_d;
    logic best_found;
    logic [3:0] best_idx;
    logic [5:0] best_key;
    logic irq_ok, trap_pend;
    logic [15:0] src_wr, src_ack;

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;
    assign branch_req = branch_req_q;
    assign branch_addr = branch_addr_q;
    assign branch_num = branch_num_q;
    assign branch_kind = kind_q;
    assign branch_level = branch_level_q;
    assign pec_req = pec_req_q;
    assign pec_src = pec_src_q;
    assign cpu_level = cpu_level_q;

    function automatic logic [6:0] src_trap(input logic [3:0] idx);
        if (idx < `ITP_IDX_CH29) begin
            src_trap = `ITP_TN_CH21 + {3'h0, idx};
        end else if (idx < `ITP_IDX_XP0) begin
            src_trap = `ITP_TN_CH29 + {3'h0, idx - `ITP_IDX_CH29};
        end else if (idx < `ITP_IDX_TXBUF) begin
            src_trap = `ITP_TN_XP0 + {3'h0, idx - `ITP_IDX_XP0};
        end else begin
            src_trap = `ITP_TN_TXBUF;
        end
    endfunction : src_trap

    // Bus slave: zero wait states, read data captured in the address phase
    assign addr_ok = hsel && htrans[1] && hready;

    always_comb begin
        be_d[0] = (hsize == `ITP_HSIZE_WORD) || (hsize == `ITP_HSIZE_HALF && !haddr[1])
            || (hsize == `ITP_HSIZE_BYTE && haddr[1:0] == 2'h0);
        be_d[1] = (hsize == `ITP_HSIZE_WORD) || (hsize == `ITP_HSIZE_HALF && !haddr[1])
            || (hsize == `ITP_HSIZE_BYTE && haddr[1:0] == 2'h1);
    end

    always_comb begin
        rd_d = 32'h0;
        if (haddr[7:0] <= `ITP_SRC_LAST && haddr[31:8] == 24'h0) begin
            rd_d[7:0] = src_ctl_q[haddr[5:2]];
        end else if (haddr[31:0] == {24'h0, `ITP_TRAP_FLAG_OFS}) begin
            rd_d[15:0] = trap_flag_q;
        end else if (haddr[31:0] == {24'h0, `ITP_PEC_ROUTE_OFS}) begin
            rd_d[15:0] = pec_route_q;
        end else if (haddr[31:0] == {24'h0, `ITP_STATUS_OFS}) begin
            rd_d[`ITP_ST_LEVEL_MSB:0] = cpu_level_q;
            rd_d[`ITP_ST_CLASS_MSB:`ITP_ST_CLASS_LSB] = active_q;
            rd_d[`ITP_ST_BRANCH_BIT] = branch_req_q;
            rd_d[`ITP_ST_PEC_BIT] = pec_req_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h0;
            wr_q <= 1'b0;
            wr_addr_q <= 8'h0;
            wr_be_q <= 2'h0;
            rd_src_q <= 1'b0;
        end else begin
            wr_q <= addr_ok && hwrite && haddr[31:8] == 24'h0;
            wr_addr_q <= haddr[7:0];
            wr_be_q <= be_d;
            rd_src_q <= addr_ok && !hwrite && haddr[7:0] <= `ITP_SRC_LAST && haddr[31:8] == 24'h0;
            if (addr_ok && !hwrite) begin
                hrdata_q <= rd_d;
            end
        end
    end

    // Nmi pin: three flops, level changes once the last two agree
    assign nmi_evt = (nmi_s2_q == nmi_s3_q) && nmi_s3_q && !nmi_lvl_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nmi_s1_q <= 1'b0;
            nmi_s2_q <= 1'b0;
            nmi_s3_q <= 1'b0;
            nmi_lvl_q <= 1'b0;
        end else begin
            nmi_s1_q <= nmi_pin;
            nmi_s2_q <= nmi_s1_q;
            nmi_s3_q <= nmi_s2_q;
            if (nmi_s2_q == nmi_s3_q) begin
                nmi_lvl_q <= nmi_s3_q;
            end
        end
    end

    // Source control registers; a request wins over a clear in the same cycle
    always_comb begin
        for (int i = 0; i < `ITP_NUM_SRC; i++) begin
            src_wr[i] = wr_q && wr_be_q[0] && wr_addr_q <= `ITP_SRC_LAST && wr_addr_q[5:2] == 4'(i);
            src_ack[i] = branch_ack && kind_q == itp_pkg::KIND_IRQ && branch_src_q == 4'(i);
            src_ack[i] = src_ack[i] || (pec_ack && pec_req_q && pec_src_q == 4'(i));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `ITP_NUM_SRC; i++) begin
                src_ctl_q[i] <= `ITP_SRC_RESET;
            end
        end else begin
            for (int i = 0; i < `ITP_NUM_SRC; i++) begin
                if (src_wr[i]) begin
                    src_ctl_q[i] <= hwdata[7:0];
                end else if (src_ack[i]) begin
                    src_ctl_q[i][`ITP_PEND_BIT] <= 1'b0;
                end
                if (src_req[i]) begin
                    src_ctl_q[i][`ITP_PEND_BIT] <= 1'b1;
                end
            end
        end
    end

    // Trap flag register, write one to clear, a new trap wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trap_flag_q <= `ITP_TF_RESET;
        end else begin
            for (int b = 0; b < 16; b++) begin
                if (wr_q && wr_addr_q == `ITP_TRAP_FLAG_OFS && wr_be_q[b / 8] && hwdata[b]) begin
                    trap_flag_q[b] <= 1'b0;
                end
            end
            if (nmi_evt) begin
                trap_flag_q[`ITP_TF_NMI] <= 1'b1;
            end
            if (stack_over_evt) begin
                trap_flag_q[`ITP_TF_OVER] <= 1'b1;
            end
            if (stack_under_evt) begin
                trap_flag_q[`ITP_TF_UNDER] <= 1'b1;
            end
            for (int b = 0; b <= `ITP_TF_CLASSB_MSB; b++) begin
                if (class_b_evt[b]) begin
                    trap_flag_q[b] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pec_route_q <= 16'h0;
        end else begin
            if (wr_q && wr_addr_q == `ITP_PEC_ROUTE_OFS && wr_be_q[0]) begin
                pec_route_q[7:0] <= hwdata[7:0];
            end
            if (wr_q && wr_addr_q == `ITP_PEC_ROUTE_OFS && wr_be_q[1]) begin
                pec_route_q[15:8] <= hwdata[15:8];
            end
        end
    end

    // Pending traps and software trap; events win over the acknowledge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_pend_q <= 1'b0;
            a_pend_q <= 3'h0;
            b_pend_q <= 1'b0;
            swt_pend_q <= 1'b0;
            swt_num_q <= 7'h0;
        end else begin
            if (branch_ack && kind_q == itp_pkg::KIND_RST) begin
                rst_pend_q <= 1'b0;
            end
            if (branch_ack && kind_q == itp_pkg::KIND_TRA) begin
                a_pend_q[branch_num_q[2:1] - 2'h1] <= 1'b0;
            end
            if (branch_ack && kind_q == itp_pkg::KIND_TRB) begin
                b_pend_q <= 1'b0;
            end
            if (branch_ack && kind_q == itp_pkg::KIND_SWT) begin
                swt_pend_q <= 1'b0;
            end
            if (|reset_evt) begin
                rst_pend_q <= 1'b1;
            end
            if (nmi_evt) begin
                a_pend_q[0] <= 1'b1;
            end
            if (stack_over_evt) begin
                a_pend_q[1] <= 1'b1;
            end
            if (stack_under_evt) begin
                a_pend_q[2] <= 1'b1;
            end
            if (|class_b_evt) begin
                b_pend_q <= 1'b1;
            end
            if (sw_trap_valid) begin
                swt_pend_q <= 1'b1;
                swt_num_q <= sw_trap_num;
            end
        end
    end

    // Arbitration: highest level, then group, then lowest index
    always_comb begin
        best_found = 1'b0;
        best_idx = 4'h0;
        best_key = 6'h0;
        for (int i = 0; i < `ITP_NUM_SRC; i++) begin
            if (src_ctl_q[i][`ITP_PEND_BIT] && src_ctl_q[i][`ITP_ENABLE_BIT]
                && (!best_found || src_ctl_q[i][`ITP_PRIORITY_LEVEL_FIELD_MSB:`ITP_GROUP_ORDER_FIELD_LSB] > best_key)) begin
                best_found = 1'b1;
                best_idx = 4'(i);
                best_key = src_ctl_q[i][`ITP_PRIORITY_LEVEL_FIELD_MSB:`ITP_GROUP_ORDER_FIELD_LSB];
            end
        end
        trap_pend = rst_pend_q || (|a_pend_q) || b_pend_q;
        irq_ok = best_found && best_key[5:2] > cpu_level_q
            && active_q == itp_pkg::CLS_NONE && !trap_pend;
    end

    // Offer selection: resets, class A, class B, software trap, interrupt
    always_comb begin
        kind_d = itp_pkg::KIND_NONE;
        num_d = `ITP_TN_RESET;
        level_d = cpu_level_q;
        if (rst_pend_q) begin
            kind_d = itp_pkg::KIND_RST;
            level_d = `ITP_LEVEL_MAX;
        end else if (|a_pend_q && active_q < itp_pkg::CLS_A) begin
            kind_d = itp_pkg::KIND_TRA;
            num_d = a_pend_q[0] ? `ITP_TN_NMI : (a_pend_q[1] ? `ITP_TN_OVER : `ITP_TN_UNDER);
            level_d = `ITP_LEVEL_MAX;
        end else if (b_pend_q && active_q < itp_pkg::CLS_B) begin
            kind_d = itp_pkg::KIND_TRB;
            num_d = `ITP_TN_CLASSB;
            level_d = `ITP_LEVEL_MAX;
        end else if (swt_pend_q) begin
            kind_d = itp_pkg::KIND_SWT;
            num_d = swt_num_q;
        end else if (irq_ok && !pec_route_q[best_idx]) begin
            kind_d = itp_pkg::KIND_IRQ;
            num_d = src_trap(best_idx);
            level_d = best_key[5:2];
        end
    end

    // Offers are refreshed every cycle and drop for one cycle after an acknowledge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            branch_req_q <= 1'b0;
            kind_q <= itp_pkg::KIND_NONE;
            branch_addr_q <= 24'h0;
            branch_num_q <= 7'h0;
            branch_level_q <= `ITP_LEVEL_RESET;
            branch_src_q <= 4'h0;
        end else begin
            branch_req_q <= !branch_ack && kind_d != itp_pkg::KIND_NONE;
            kind_q <= branch_ack ? itp_pkg::KIND_NONE : kind_d;
            branch_addr_q <= {15'h0, num_d, 2'h0};
            branch_num_q <= num_d;
            branch_level_q <= level_d;
            branch_src_q <= best_idx;
        end
    end

    // A transfer request costs no vector, only one stolen cycle at the core
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pec_req_q <= 1'b0;
            pec_src_q <= 4'h0;
        end else begin
            pec_req_q <= !pec_ack && irq_ok && pec_route_q[best_idx];
            pec_src_q <= best_idx;
        end
    end

    // Processor level and active trap class; one saved level, so nested traps restore 15
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_level_q <= `ITP_LEVEL_RESET;
            saved_level_q <= `ITP_LEVEL_RESET;
            active_q <= itp_pkg::CLS_NONE;
        end else if (branch_ack && branch_req_q) begin
            unique case (kind_q)
                itp_pkg::KIND_RST, itp_pkg::KIND_TRA, itp_pkg::KIND_TRB: begin
                    saved_level_q <= cpu_level_q;
                    cpu_level_q <= `ITP_LEVEL_MAX;
                    active_q <= kind_q == itp_pkg::KIND_RST ? itp_pkg::CLS_RST
                        : (kind_q == itp_pkg::KIND_TRA ? itp_pkg::CLS_A : itp_pkg::CLS_B);
                end
                itp_pkg::KIND_IRQ: begin
                    cpu_level_q <= branch_level_q;
                end
                default: begin
                end
            endcase
        end else if (trap_done) begin
            active_q <= itp_pkg::CLS_NONE;
            cpu_level_q <= saved_level_q;
        end else if (irq_return) begin
            cpu_level_q <= ret_level;
        end
    end

    reset_vec_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rst_pend_q && !branch_ack |=> branch_req_q && kind_q == itp_pkg::KIND_RST
        && branch_addr_q == 24'h0 && branch_num_q == 7'h0)
        else $error("Reset not offered at vector zero");

    class_a_vec_a: assert property (@(posedge hclk) disable iff (!hresetn)
        branch_req_q && kind_q == itp_pkg::KIND_TRA |-> (branch_num_q == 7'h02 || branch_num_q == 7'h04
        || branch_num_q == 7'h06) && branch_addr_q == {15'h0, branch_num_q, 2'h0})
        else $error("Class A trap number or vector wrong");

    class_b_vec_a: assert property (@(posedge hclk) disable iff (!hresetn)
        branch_req_q && kind_q == itp_pkg::KIND_TRB |-> branch_addr_q == 24'h000028 && branch_num_q == 7'h0a)
        else $error("Class B trap vector wrong");

    trap_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        branch_ack && branch_req_q && kind_q inside {itp_pkg::KIND_RST, itp_pkg::KIND_TRA, itp_pkg::KIND_TRB}
        |=> cpu_level_q == 4'hf && active_q != itp_pkg::CLS_NONE)
        else $error("Trap service did not force level 15");

    trap_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        stack_over_evt ##1 1'b1 |-> trap_flag_q[`ITP_TF_OVER] && a_pend_q[1] || $past(branch_ack))
        else $error("Stack overflow not flagged");

    trap_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
        active_q != itp_pkg::CLS_NONE ##1 active_q != itp_pkg::CLS_NONE
        |-> !pec_req_q && !(branch_req_q && kind_q == itp_pkg::KIND_IRQ))
        else $error("Interrupt offered during trap service");

    irq_higher_a: assert property (@(posedge hclk) disable iff (!hresetn)
        branch_req_q && kind_q == itp_pkg::KIND_IRQ |-> branch_level_q > cpu_level_q)
        else $error("Interrupt offered at no higher level");

    irq_accept_a: assert property (@(posedge hclk) disable iff (!hresetn)
        branch_ack && branch_req_q && kind_q == itp_pkg::KIND_IRQ && !src_req[branch_src_q] && !src_wr[branch_src_q]
        |=> !src_ctl_q[$past(branch_src_q)][`ITP_PEND_BIT] && cpu_level_q == $past(branch_level_q))
        else $error("Accepted interrupt left pending");

    swt_vec_a: assert property (@(posedge hclk) disable iff (!hresetn)
        branch_req_q && kind_q == itp_pkg::KIND_SWT
        |-> branch_addr_q == {15'h0, branch_num_q, 2'h0} && branch_level_q == $past(cpu_level_q))
        else $error("Software trap vector or level wrong");

    upper_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_src_q |-> hrdata_q[31:8] == 24'h0)
        else $error("Source register upper bits not zero");

    irq_taken_c: cover property (@(posedge hclk) disable iff (!hresetn)
        branch_req_q && branch_ack && kind_q == itp_pkg::KIND_IRQ);
    trap_taken_c: cover property (@(posedge hclk) disable iff (!hresetn)
        branch_req_q && branch_ack && kind_q == itp_pkg::KIND_TRA);
    pec_taken_c: cover property (@(posedge hclk) disable iff (!hresetn) pec_req_q && pec_ack);
    swt_taken_c: cover property (@(posedge hclk) disable iff (!hresetn)
        branch_req_q && branch_ack && kind_q == itp_pkg::KIND_SWT);

endmodule : itp_prioritizer

// ---- verif/itp_core_model.sv ----
// Processor core model: accepts offers, ends services
`timescale 1ns/100ps
module itp_core_model #(parameter int ACK_DLY = 2) (
    // Clock, reset and offers
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic branch_req,
    input wire logic [2:0] branch_kind,
    input wire logic pec_req,
    // Answers
    output logic branch_ack,
    output logic trap_done,
    output logic irq_return,
    output logic [3:0] ret_level,
    output logic pec_ack
);
    logic [3:0] cnt_q;
    logic [3:0] done_q;
    logic [2:0] kind_q;
    // Long service time so that held-off requests are seen waiting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {branch_ack, pec_ack, trap_done, irq_return, ret_level} <= '0;
            {cnt_q, done_q, kind_q} <= '0;
        end else begin
            branch_ack <= 1'b0;
            trap_done <= 1'b0;
            irq_return <= 1'b0;
            pec_ack <= pec_req && !pec_ack;
            if (branch_req && !branch_ack) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == 4'(ACK_DLY)) begin
                    branch_ack <= 1'b1;
                    cnt_q <= 4'h0;
                    kind_q <= branch_kind;
                    done_q <= 4'hf;
                end
            end
            if (done_q != 4'h0) begin
                done_q <= done_q - 4'h1;
                if (done_q == 4'h1) begin
                    trap_done <= (kind_q == 3'h2) || (kind_q >= 3'h6);
                    irq_return <= (kind_q == 3'h1);
                end
            end
        end
    end
endmodule : itp_core_model

// ---- verif/itp_prioritizer_tb_top.sv ----
// Testbench of the interrupt and trap prioritizer
`timescale 1ns/100ps
module itp_prioritizer_tb_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, nmi_pin = 0, so = 0, su = 0, swv = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, rst_e = 0, bkind;
    logic [15:0] src_req = 0;
    logic [5:0] cb = 0;
    logic [6:0] swn = 0, bnum;
    logic hreadyout, hresp, breq, back, tdone, iret, pec_req, pec_ack;
    logic [23:0] baddr;
    logic [3:0] blvl, rlvl, pec_src, cpu_level;
    int n_errors = 0, checks_done = 0;
    itp_prioritizer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .src_req(src_req), .reset_evt(rst_e), .nmi_pin(nmi_pin),
        .stack_over_evt(so), .stack_under_evt(su), .class_b_evt(cb), .sw_trap_valid(swv),
        .sw_trap_num(swn), .branch_req(breq), .branch_addr(baddr), .branch_num(bnum),
        .branch_kind(bkind), .branch_level(blvl), .branch_ack(back), .trap_done(tdone),
        .irq_return(iret), .ret_level(rlvl), .pec_req(pec_req), .pec_src(pec_src), .pec_ack(pec_ack),
        .cpu_level(cpu_level));
    itp_core_model u_core (.hclk(hclk), .hresetn(hresetn), .branch_req(breq), .branch_kind(bkind),
        .pec_req(pec_req), .branch_ack(back), .trap_done(tdone), .irq_return(iret), .ret_level(rlvl),
        .pec_ack(pec_ack));
    initial forever #12.5 hclk = ~hclk;
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    task chk(input logic [63:0] s, input logic [63:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, w};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        {htrans, hwdata} <= {2'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask : xfer
    task req(input int i);
        @(posedge hclk);
        src_req <= 16'h1 << i;
        @(posedge hclk);
        src_req <= 16'h0;
    endtask : req
    // Waits for an offer, compares it, then waits for the core to take it
    task offer(input logic [2:0] k, input logic [6:0] n, input logic [3:0] l);
        int t;
        t = 0;
        while (breq !== 1'b1 && t < 80) begin
            @(negedge hclk);
            t++;
        end
        chk({bkind, bnum, baddr, blvl}, {k, n, 15'h0, n, 2'h0, l});
        while (breq === 1'b1 && t < 80) begin
            @(negedge hclk);
            t++;
        end
    endtask : offer
    function logic [6:0] tn(input int i);
        if (i < 8) return 7'(7'h35 + i);
        if (i < 11) return 7'(7'h44 + i - 8);
        if (i < 15) return 7'(7'h40 + i - 11);
        return 7'h47;
    endfunction : tn
    task t_regs;
        xfer(0, 32'h0, 0);
        chk(rdv, 0);
        chk(hresp, 0);
        xfer(1, 32'hc, 32'hffffff3f);
        xfer(0, 32'hc, 0);
        chk(rdv, 32'h3f);
        xfer(0, 32'h80, 0);
        chk(rdv, 0);
        xfer(1, 32'hc, 0);
    endtask : t_regs
    task t_map;
        int s[7];
        s = '{0, 7, 8, 10, 11, 14, 15};
        foreach (s[j]) begin
            xfer(1, 32'(4 * s[j]), 32'h44);
            req(s[j]);
            offer(3'h1, tn(s[j]), 4'h1);
            chk(cpu_level, 4'h1);
            xfer(0, 32'(4 * s[j]), 0);
            chk(rdv, 32'h44);
            cyc(16);
            xfer(1, 32'(4 * s[j]), 0);
        end
    endtask : t_map
    // Equal level tie, with a disabled higher level source that must not win
    task t_grp;
        xfer(1, 32'h4, 32'h48);
        xfer(1, 32'h8, 32'h4b);
        xfer(1, 32'hc, 32'h0c);
        @(posedge hclk);
        src_req <= 16'he;
        cyc(1);
        src_req <= 16'h0;
        offer(3'h1, 7'h37, 4'h2);
        cyc(4);
        @(negedge hclk);
        chk(breq, 0);
        offer(3'h1, 7'h36, 4'h2);
        xfer(0, 32'hc, 0);
        chk(rdv, 32'h8c);
        xfer(1, 32'hc, 0);
        cyc(16);
    endtask : t_grp
    task t_trap;
        @(posedge hclk);
        {so, cb} <= {1'b1, 6'h10};
        @(posedge hclk);
        {so, cb} <= 0;
        offer(3'h6, 7'h04, 4'hf);
        chk(cpu_level, 4'hf);
        xfer(0, 32'h48, 0);
        chk(rdv, 32'h2f);
        req(1);
        cyc(6);
        @(negedge hclk);
        chk(breq, 0);
        offer(3'h2, 7'h0a, 4'hf);
        offer(3'h1, 7'h36, 4'h2);
        xfer(0, 32'h40, 0);
        chk(rdv, 32'h4010);
        xfer(1, 32'h40, 32'hffff);
        cyc(16);
    endtask : t_trap
    task t_cb;
        for (int b = 0; b < 6; b++) begin
            @(posedge hclk);
            cb <= 6'(6'h1 << b);
            @(posedge hclk);
            cb <= 6'h0;
            offer(3'h2, 7'h0a, 4'hf);
            xfer(0, 32'h40, 0);
            chk(rdv, 32'h1 << b);
            xfer(1, 32'h40, 32'hffff);
            cyc(16);
        end
    endtask : t_cb
    task t_misc;
        int t;
        // Pin passes the synchroniser before the trap is seen
        @(posedge hclk);
        nmi_pin <= 1'b1;
        cyc(4);
        nmi_pin <= 1'b0;
        offer(3'h6, 7'h02, 4'hf);
        @(posedge hclk);
        su <= 1'b1;
        @(posedge hclk);
        su <= 1'b0;
        offer(3'h6, 7'h06, 4'hf);
        xfer(0, 32'h40, 0);
        chk(rdv, 32'ha000);
        xfer(1, 32'h40, 32'hffff);
        cyc(16);
        for (int b = 0; b < 3; b++) begin
            @(posedge hclk);
            rst_e <= 3'(3'h1 << b);
            @(posedge hclk);
            rst_e <= 3'h0;
            offer(3'h7, 7'h00, 4'hf);
            cyc(16);
        end
        @(posedge hclk);
        {swv, swn} <= {1'b1, 7'h7f};
        @(posedge hclk);
        swv <= 1'b0;
        offer(3'h3, 7'h7f, 4'h0);
        xfer(1, 32'h44, 32'h2);
        xfer(1, 32'h4, 32'h48);
        req(1);
        t = 0;
        while (pec_req !== 1'b1 && t < 40) begin
            @(negedge hclk);
            t++;
        end
        chk({breq, pec_src, cpu_level}, {1'b0, 4'h1, 4'h0});
        cyc(4);
        xfer(0, 32'h4, 0);
        chk(rdv, 32'h48);
    endtask : t_misc
    initial begin
        #(25 * 20000);
        n_errors++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_map;
        t_grp;
        t_trap;
        t_cb;
        t_misc;
        end_of_test;
    end
endmodule : itp_prioritizer_tb_top
